// ==== rtl/txwp_top.sv ====
/*
 * Transmit word unpacker: samples the 22-bit fabric word on each clock with tx_valid high and
 * presents per-lane symbol, control and disparity fields plus the PIPE
 * compliance and electrical idle requests. Width and mode come from an
 * APB control register; status and counters are readable over APB.
 * Assumes the fabric word is generated on pclk.
 */
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module txwp_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Fabric word
    input  wire logic                          tx_valid,
    input  wire logic [txwp_pkg::WORD_W-1:0]   tx_word,
    // Channel side
    output logic                               lane0_valid,
    output logic      [txwp_pkg::SYM_W-1:0]    lane0_sym,
    output logic                               lane0_ctrl,
    output logic                               lane0_fdisp_en,
    output logic                               lane0_fdisp_val,
    output logic                               lane1_valid,
    output logic      [txwp_pkg::SYM_W-1:0]    lane1_sym,
    output logic                               lane1_ctrl,
    output logic                               lane1_fdisp_en,
    output logic                               lane1_fdisp_val,
    output logic                               compliance,
    output logic                               elec_idle
);
    import txwp_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0]               width_sel;
    logic                     pipe_mode;
    logic                     enc_on;
    logic                     hi_disp_err;
    logic                     idle_mism;
    logic [WORD_W-1:0]        last_word;
    logic [CNT_W-1:0]         word_cnt;
    logic [CNT_W-1:0]         ctrl_cnt;
    logic                     raw_sym;
    logic                     dual;
    logic [SYM_W-1:0]         l0_sym;
    logic                     l0_ctrl;
    logic                     l0_fen;
    logic                     l0_fval;
    logic [SYM_W-1:0]         l1_sym;
    logic                     l1_ctrl;
    logic                     l1_fen;
    logic                     l1_fval;
    logic                     setup_ok;
    logic                     wr_go;
    logic                     next_hi_disp_err;
    logic                     next_idle_mism;
    logic                     wr_wordcnt;
    logic                     wr_ctrlcnt;
    logic                     ctrl_event;
    logic                     sample;
    logic [31:0]              next_prdata;
    logic                     next_pslverr;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Raw symbols in 10 and 20 bit widths, two lanes in 16 and 20
    assign raw_sym = (width_sel == WIDTH_10) || (width_sel == WIDTH_20);  // [R6]
    assign dual    = (width_sel == WIDTH_16) || (width_sel == WIDTH_20);  // [R14]
    assign sample  = tx_valid;

    // ------------------------------------------------------------
    // Lane field split
    // ------------------------------------------------------------
    txwp_lane u_lane0 (
        .slice     (tx_word[LO_BASE +: SLICE_W]),
        .raw_sym   (raw_sym),
        .enc_on    (enc_on),
        .pipe      (pipe_mode),
        .sym       (l0_sym),
        .ctrl      (l0_ctrl),
        .fdisp_en  (l0_fen),
        .fdisp_val (l0_fval)
    );

    txwp_lane u_lane1 (
        .slice     (tx_word[HI_BASE +: SLICE_W]),
        .raw_sym   (raw_sym),
        .enc_on    (enc_on),
        .pipe      (pipe_mode),
        .sym       (l1_sym),
        .ctrl      (l1_ctrl),
        .fdisp_en  (l1_fen),
        .fdisp_val (l1_fval)
    );

    // ------------------------------------------------------------
    // Lane 0 output stage
    // ------------------------------------------------------------
    // Every field of the word is taken on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane0_valid     <= 1'b0;
            lane0_sym       <= '0;
            lane0_ctrl      <= 1'b0;
            lane0_fdisp_en  <= 1'b0;
            lane0_fdisp_val <= 1'b0;
        end else begin
            lane0_valid     <= sample;                          // [R15]
            lane0_sym       <= sample ? l0_sym : '0;            // [R15]
            lane0_ctrl      <= sample & l0_ctrl;
            lane0_fdisp_en  <= sample & l0_fen;
            lane0_fdisp_val <= sample & l0_fval;
        end
    end

    // ------------------------------------------------------------
    // Lane 1 output stage
    // ------------------------------------------------------------
    // Upper slice is ignored in single-lane widths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane1_valid     <= 1'b0;
            lane1_sym       <= '0;
            lane1_ctrl      <= 1'b0;
            lane1_fdisp_en  <= 1'b0;
            lane1_fdisp_val <= 1'b0;
        end else begin
            lane1_valid     <= sample & dual;                   // [R15]
            lane1_sym       <= (sample & dual) ? l1_sym : '0;   // [R7] [R13] [R14]
            lane1_ctrl      <= sample & dual & l1_ctrl;         // [R8]
            lane1_fdisp_en  <= sample & dual & l1_fen;          // [R9]
            lane1_fdisp_val <= sample & dual & l1_fval;         // [R11]
        end
    end

    // ------------------------------------------------------------
    // PIPE requests
    // ------------------------------------------------------------
    // Bit 9 asks for compliance disparity, bit 10 for electrical idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compliance <= 1'b0;
            elec_idle  <= 1'b0;
        end else begin
            compliance <= sample & pipe_mode & ~raw_sym & tx_word[POS_FDISP];   // [R3]
            elec_idle  <= sample & pipe_mode & ~raw_sym & tx_word[POS_DISPVAL]; // [R5] [R12]
        end
    end

    // ------------------------------------------------------------
    // Fabric misuse flags
    // ------------------------------------------------------------
    // Bit 20 must stay low and bits 10 and 21 must agree in 16-bit PIPE
    always_comb begin
        next_hi_disp_err = 1'b0;
        next_idle_mism   = 1'b0;
        if (sample && pipe_mode && width_sel == WIDTH_16) begin
            next_hi_disp_err = tx_word[HI_BASE + POS_FDISP];                  // [R10]
            next_idle_mism   = tx_word[POS_DISPVAL]
                             ^ tx_word[HI_BASE + POS_DISPVAL];               // [R12]
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_disp_err <= 1'b0;
            idle_mism   <= 1'b0;
        end else begin
            hi_disp_err <= next_hi_disp_err
                         | (hi_disp_err & ~(wr_go && paddr == OFS_STATUS
                                            && pwdata[STAT_HI_DISP_ERR]));
            idle_mism   <= next_idle_mism
                         | (idle_mism & ~(wr_go && paddr == OFS_STATUS
                                          && pwdata[STAT_IDLE_MISM]));
        end
    end

    // ------------------------------------------------------------
    // Word capture and counters
    // ------------------------------------------------------------
    // Last word sampled, for software inspection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_word <= '0;
        end else if (sample) begin
            last_word <= tx_word;                               // [R15]
        end
    end

    assign ctrl_event = (sample & l0_ctrl) | (sample & dual & l1_ctrl);
    assign wr_wordcnt = wr_go && (paddr == OFS_WORDCNT);
    assign wr_ctrlcnt = wr_go && (paddr == OFS_CTRLCNT);

    txwp_counter u_word_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (wr_wordcnt),
        .inc     (sample),
        .count   (word_cnt)
    );

    txwp_counter u_ctrl_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (wr_ctrlcnt),
        .inc     (ctrl_event),
        .count   (ctrl_cnt)
    );

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign setup_ok = psel && penable && !pready;
    assign wr_go    = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_ok;
        end
    end

    // Control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_sel <= CTRL_RESET[CTRL_WIDTH_LSB +: 2];
            pipe_mode <= CTRL_RESET[CTRL_PIPE];
            enc_on    <= CTRL_RESET[CTRL_ENC];
        end else if (wr_go && paddr == OFS_CTRL) begin
            width_sel <= pwdata[CTRL_WIDTH_LSB +: 2];
            pipe_mode <= pwdata[CTRL_PIPE];
            enc_on    <= pwdata[CTRL_ENC];
        end
    end

    // Read mux and unmapped-address error
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (paddr == OFS_CTRL) begin
            next_prdata[CTRL_WIDTH_LSB +: 2] = width_sel;
            next_prdata[CTRL_PIPE]           = pipe_mode;
            next_prdata[CTRL_ENC]            = enc_on;
        end else if (paddr == OFS_STATUS) begin
            next_prdata[STAT_HI_DISP_ERR] = hi_disp_err;
            next_prdata[STAT_IDLE_MISM]   = idle_mism;
        end else if (paddr == OFS_LASTW) begin
            next_prdata[WORD_W-1:0] = last_word;
        end else if (paddr == OFS_WORDCNT) begin
            next_prdata = word_cnt;
        end else if (paddr == OFS_CTRLCNT) begin
            next_prdata = ctrl_cnt;
        end else begin
            next_pslverr = 1'b1;
        end
    end

    // Answer registers, valid while pready is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ok) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

endmodule : txwp_top

// ==== shared/txwp_pkg.sv ====
/*
 * Constants of the transmit word unpacker: offsets, field positions,
 * reset values and width encodings.
 * Assumes an APB master with 32-bit data and byte addresses.
 */
// Operation
// [R1] 8-bit width: bits 7:0 carry data byte
// [R2] 8-bit 8B/10B: bit 8 flags control code
// [R3] 8-bit: bit 9 force-disparity, compliance in PIPE
// [R4] 8-bit non-PIPE: bit 10 is disparity value
// [R5] 8-bit PIPE: bit 10 requests electrical idle
// [R6] 10/20-bit: bits 9:0 carry low symbol
// [R7] 16-bit: low byte 7:0, high byte 18:11
// [R8] 16-bit 8B/10B: control flags bits 8, 19
// [R9] 16-bit non-PIPE: force enables bits 9, 20
// [R10] 16-bit PIPE: fabric holds bit 20 low
// [R11] 16-bit non-PIPE: disparity values bits 10, 21
// [R12] 16-bit PIPE: bits 10, 21 electrical idle
// [R13] 20-bit: high symbol in bits 20:11
// [R14] Unassigned bits for width/mode are ignored
// [R15] Whole word sampled on one edge
package txwp_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int WORD_W      = 22;
    localparam int SLICE_W     = 11;
    localparam int SYM_W       = 10;
    localparam int LO_BASE     = 0;
    localparam int HI_BASE     = 11;
    localparam int POS_CTRL    = 8;
    localparam int POS_FDISP   = 9;
    localparam int POS_DISPVAL = 10;

    // ------------------------------------------------------------
    // Interface width encodings
    // ------------------------------------------------------------
    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_10 = 2'h1;
    localparam logic [1:0] WIDTH_16 = 2'h2;
    localparam logic [1:0] WIDTH_20 = 2'h3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_LASTW   = 8'h08;
    localparam logic [7:0] OFS_WORDCNT = 8'h0C;
    localparam logic [7:0] OFS_CTRLCNT = 8'h10;

    // Control register fields
    localparam int CTRL_WIDTH_LSB = 0;
    localparam int CTRL_PIPE      = 2;
    localparam int CTRL_ENC       = 3;
    localparam logic [3:0] CTRL_RESET = 4'h8;

    // Status register fields
    localparam int STAT_HI_DISP_ERR = 0;
    localparam int STAT_IDLE_MISM   = 1;

    // Counter width
    localparam int CNT_W = 32;

endpackage : txwp_pkg

// ==== rtl/txwp_lane.sv ====
/*
 * One lane of the transmit word: splits an 11-bit slice into symbol,
 * control flag and forced-disparity controls.
 * Assumes the caller selects the slice and the mode; purely combinational.
 */
`timescale 1ns/1ps
module txwp_lane (
    input  wire logic [txwp_pkg::SLICE_W-1:0] slice,
    input  wire logic                         raw_sym,
    input  wire logic                         enc_on,
    input  wire logic                         pipe,
    output logic      [txwp_pkg::SYM_W-1:0]   sym,
    output logic                              ctrl,
    output logic                              fdisp_en,
    output logic                              fdisp_val
);
    import txwp_pkg::*;

    // ------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------
    // Raw 10-bit symbols pass untouched and carry no flags
    always_comb begin
        if (raw_sym) begin
            sym       = slice[SYM_W-1:0];                      // [R6] [R13]
            ctrl      = 1'b0;                                  // [R14]
            fdisp_en  = 1'b0;
            fdisp_val = 1'b0;
        end else begin
            sym       = {2'b00, slice[7:0]};                   // [R1] [R7]
            ctrl      = slice[POS_CTRL] & enc_on;              // [R2] [R8]
            fdisp_en  = slice[POS_FDISP] & ~pipe;              // [R3] [R9]
            fdisp_val = slice[POS_DISPVAL] & ~pipe;            // [R4] [R11]
        end
    end

endmodule : txwp_lane

// ==== rtl/txwp_counter.sv ====
/*
 * Free event counter with synchronous clear; the clear loses to nothing,
 * an event in the clearing cycle counts as one.
 * Assumes pclk and presetn of the block.
 */
`timescale 1ns/1ps
module txwp_counter (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       clr,
    input  wire logic                       inc,
    output logic      [txwp_pkg::CNT_W-1:0] count
);
    import txwp_pkg::*;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Clear and event together leave a count of one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clr) begin
            count <= {{(CNT_W-1){1'b0}}, inc};
        end else if (inc) begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule : txwp_counter

// ==== dv/txwp_top_sva.sv ====
/*
 * Port checker of the transmit word unpacker.
 * Assumes it is bound to txwp_top; it follows width and mode from APB writes.
 */
`timescale 1ns/1ps
module txwp_top_sva (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [7:0]                  paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic                        tx_valid,
    input wire logic [txwp_pkg::WORD_W-1:0] tx_word,
    input wire logic                        lane0_valid,
    input wire logic [txwp_pkg::SYM_W-1:0]  lane0_sym,
    input wire logic                        lane0_ctrl,
    input wire logic                        lane0_fdisp_en,
    input wire logic                        lane0_fdisp_val,
    input wire logic                        lane1_valid,
    input wire logic [txwp_pkg::SYM_W-1:0]  lane1_sym,
    input wire logic                        lane1_ctrl,
    input wire logic                        lane1_fdisp_en,
    input wire logic                        lane1_fdisp_val,
    input wire logic                        compliance,
    input wire logic                        elec_idle
);
    import txwp_pkg::*;
    logic [3:0] mode;
    logic       bw, two, np_b, pp_b, ct_b;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Mode as last written over APB
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= CTRL_RESET;
        end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
            mode <= pwdata[3:0];
        end
    end
    // Byte width, two lanes, PIPE and encoder qualifiers
    assign bw = !mode[0];
    assign two = mode[1];
    assign np_b = bw && !mode[2];
    assign pp_b = bw && mode[2];
    assign ct_b = bw && mode[3];
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_valid_follow: assert property (tx_valid |=>
        lane0_valid && lane1_valid == $past(two))
        else $error("lane valid does not follow sampled word");
    a_idle_quiet: assert property (!tx_valid |=> !lane0_valid && !lane1_valid)
        else $error("lane valid without sampled word");
    a_lane0_byte: assert property (tx_valid && bw |=>
        lane0_sym == {2'b00, $past(tx_word[7:0])})
        else $error("low byte misplaced");
    a_raw_symbol: assert property (tx_valid && !bw |=> lane0_sym == $past(tx_word[9:0]))
        else $error("low raw symbol misplaced");
    a_ctrl_flag: assert property (tx_valid |=>
        lane0_ctrl == $past(ct_b && tx_word[8]))
        else $error("low control flag wrong");
    a_lane0_disp: assert property (tx_valid |=>
        lane0_fdisp_en == $past(np_b && tx_word[9]) && lane0_fdisp_val == $past(np_b && tx_word[10]))
        else $error("low forced disparity wrong");
    a_pipe_req: assert property (tx_valid |=>
        compliance == $past(pp_b && tx_word[9]) && elec_idle == $past(pp_b && tx_word[10]))
        else $error("compliance or electrical idle wrong");
    a_lane1_sym: assert property (tx_valid && two |=>
        lane1_sym == $past(bw ? {2'b00, tx_word[18:11]} : tx_word[20:11]))
        else $error("high symbol misplaced");
    a_lane1_flags: assert property (tx_valid && two |=>
        lane1_ctrl == $past(ct_b && tx_word[19]) && lane1_fdisp_en == $past(np_b && tx_word[20])
        && lane1_fdisp_val == $past(np_b && tx_word[21]))
        else $error("high lane flags wrong");
    a_ready_timing: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("ready not in second access cycle");
    a_unmapped_err: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFS_CTRLCNT))
        else $error("error response wrong for address");
    // Main scenarios
    c_pipe16: cover property (tx_valid && two && pp_b);
    c_raw20: cover property (tx_valid && two && !bw);
    c_refused: cover property (pready && pslverr);
endmodule : txwp_top_sva

bind txwp_top txwp_top_sva u_sva (.*);

// ==== dv/txwp_fab_model.sv ====
/*
 * Fabric source model: presents one transmit word per call.
 * Assumes the caller knows when 16-bit PIPE mode is active.
 */
`timescale 1ns/1ps
module txwp_fab_model (
    input  wire logic                        pclk,
    input  wire logic                        pipe16,
    input  wire logic                        break_r10,
    output logic                             tx_valid,
    output logic [txwp_pkg::WORD_W-1:0]      tx_word
);
    import txwp_pkg::*;
    initial {tx_valid, tx_word} = '0;
    // Whole word presented together after one edge
    task automatic send(input logic [WORD_W-1:0] w);
        @(posedge pclk);
        tx_valid <= 1'b1;
        tx_word <= (pipe16 && !break_r10) ? (w & 22'h2f_ffff) : w;
    endtask : send
    // Released word shows the inverse so stale data never matches
    task automatic idle;
        @(posedge pclk);
        tx_valid <= 1'b0;
        tx_word <= ~tx_word;
    endtask : idle
endmodule : txwp_fab_model

// ==== dv/test_tx_fabric_word_packing.sv ====
/*
 * Bench of the word unpacker: APB tasks and per-cycle lane checks.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
module test_tx_fabric_word_packing;
    import txwp_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, brk;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, lastw;
    logic        tx_valid, l0v, l0c, l0e, l0d, l1v, l1c, l1e, l1d, comp, eidle;
    logic [21:0] tx_word;
    logic [9:0]  l0s, l1s;
    logic [3:0]  mode_q;
    logic [29:0] exp_q;
    logic [21:0] pats [5] = '{22'h3f_ffff, 22'h00_0000, 22'h2a_aaaa, 22'h15_5555, 22'h30_0500};
    int          fails, cmp_count, wcount, ccount, cycles;

    txwp_top u_txwp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_valid(tx_valid), .tx_word(tx_word), .lane0_valid(l0v),
        .lane0_sym(l0s), .lane0_ctrl(l0c), .lane0_fdisp_en(l0e), .lane0_fdisp_val(l0d),
        .lane1_valid(l1v), .lane1_sym(l1s), .lane1_ctrl(l1c), .lane1_fdisp_en(l1e),
        .lane1_fdisp_val(l1d), .compliance(comp), .elec_idle(eidle));
    txwp_fab_model u_txwp_fab_model (.pclk(pclk), .pipe16(mode_q[2:0] == 3'h6),
        .break_r10(brk), .tx_valid(tx_valid), .tx_word(tx_word));

    // ----------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Expected lane outputs of one sampled word
    // ----------------------------------------
    function automatic logic [29:0] exp_out(logic v, logic [21:0] w, logic [3:0] m);
        logic b, t;
        b = !m[0];
        t = m[1];
        if (!v) return 30'h0000_0000;
        return {1'b1, b ? {2'b00, w[7:0]} : w[9:0], b & m[3] & w[8], b & !m[2] & w[9],
            b & !m[2] & w[10], t, t ? (b ? {2'b00, w[18:11]} : w[20:11]) : 10'h000,
            t & b & m[3] & w[19], t & b & !m[2] & w[20], t & b & !m[2] & w[21],
            b & m[2] & w[9], b & m[2] & w[10]};
    endfunction : exp_out
    task automatic cmp_out(input logic [29:0] got, input logic [29:0] exp);
        logic [29:0] msk;
        msk = exp[29] ? 30'h3fff_ffff : 30'h2000_8000;
        cmp_count++;
        if ((got & msk) !== exp) begin
            fails++;
            $display("CHECK FAILED %0t lanes %h expected %h", $time, got, exp);
        end
    endtask : cmp_out
    task automatic cmp_reg(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t register %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg
    // Expectation and counts from the word sampled at each edge
    always @(posedge pclk) begin
        exp_q <= exp_out(tx_valid, tx_word, mode_q);
        if (presetn && tx_valid) begin
            wcount++;
            lastw = {10'h000, tx_word};
            if (!mode_q[0] && mode_q[3] && (tx_word[8] || (mode_q[1] && tx_word[19]))) ccount++;
        end
    end
    always @(negedge pclk) begin
        if (presetn) cmp_out({l0v, l0s, l0c, l0e, l0d, l1v, l1s, l1c, l1e, l1d, comp, eidle},
            exp_q);
    end

    // ----------------------------------------
    // APB master
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [32:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = {pslverr, prdata};
        if (wr && a == OFS_CTRL && !pslverr) mode_q <= d[3:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] rd;
        apb(1'b1, a, d, rd);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [32:0] exp);
        logic [32:0] rd;
        apb(1'b0, a, 32'h0000_0000, rd);
        cmp_reg(rd, exp);
    endtask : rd_chk

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, brk} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        mode_q = CTRL_RESET;
        exp_q = 30'h0000_0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(OFS_CTRL, 33'h0_0000_0008);
        rd_chk(8'h14, 33'h1_0000_0000);
        wr(8'h14, 32'h0000_0003);
        rd_chk(OFS_CTRL, 33'h0_0000_0008);
        // Every width, PIPE and encoder setting with back-to-back words
        for (int m = 0; m < 16; m++) begin
            wr(OFS_CTRL, 32'(m));
            foreach (pats[i]) u_txwp_fab_model.send(pats[i]);
            u_txwp_fab_model.idle();
        end
        // Mode change in the middle of a stream
        fork
            wr(OFS_CTRL, 32'h0000_000a);
            for (int i = 0; i < 10; i++) u_txwp_fab_model.send(pats[i % 5]);
        join
        u_txwp_fab_model.idle();
        repeat (2) @(posedge pclk);
        rd_chk(OFS_WORDCNT, {1'b0, 32'(wcount)});
        rd_chk(OFS_CTRLCNT, {1'b0, 32'(ccount)});
        rd_chk(OFS_LASTW, {1'b0, lastw});
        wr(OFS_WORDCNT, 32'h0000_0000);
        wcount = 0;
        rd_chk(OFS_WORDCNT, 33'h0_0000_0000);
        // Fabric breaking the high-lane rules in 16-bit PIPE mode
        wr(OFS_CTRL, 32'h0000_0006);
        wr(OFS_STATUS, 32'h0000_0003);
        rd_chk(OFS_STATUS, 33'h0_0000_0000);
        brk <= 1'b1;
        u_txwp_fab_model.send(22'h10_0400);
        u_txwp_fab_model.idle();
        brk <= 1'b0;
        repeat (2) @(posedge pclk);
        rd_chk(OFS_STATUS, 33'h0_0000_0003);
        wr(OFS_STATUS, 32'h0000_0001);
        rd_chk(OFS_STATUS, 33'h0_0000_0002);
        finish_test();
    end
endmodule : test_tx_fabric_word_packing
